// [rtl/axis_command_request_arbiter.sv]
// Per-axis request words, priority arbitration of starts and stops, servo lock latch.
// Assumes pulse generators and the host port run on clk; completion and error
// strobes arrive as one-cycle pulses from the generators.
//
// Contract
// [R1] Rising single_move_start launches a single target move.
// [R2] Rising multi_point_start launches a chained target move.
// [R3] Rising home_return_start launches a home return.
// [R4] Rising jog_fwd or jog_rev launches JOG forward or reverse.
// [R5] forced_stop ends any running operation at once, no ramp.
// [R6] decel_stop makes the running operation decelerate to standstill.
// [R7] Pulser input is enabled only while pulser_enable is high.
// [R8] jog_position_arm starts JOG positioning, active while held high.
// [R9] jog_position_trigger acts only when arm already high; not arbitrated.
// [R10] Edge of servo_lock_req sets the servo-on output, which then holds.
// [R11] Edge of servo_release_req clears servo-on; the only way to release.
// [R12] Going to halt mode leaves servo-on unchanged.
// [R13] Servo-on state of every axis is readable by the host.
// [R14] Rising error_clear clears the pending axis error.
// [R15] While a stop bit is high no start is accepted.
// [R16] While a stop bit is high error_clear is not executed.
// [R17] Several simultaneous requests at idle: only highest priority starts.
// [R18] While running, new operation requests are ignored.
// [R19] Servo lock and release bypass motion arbitration.
// [R20] Host locks the servo before requesting motion.
// [R21] Host clears stop bits before new request or error clear.
// [R22] Four request words at consecutive word offsets from the base.
// [R23] Busy is high from operation start until completion.
// [R24] Done rises at completion or stop; falls when next operation starts.
// [R25] With both stop bits high, forced stop wins.
// [R26] Starts act on the rising edge of the request bit.
`timescale 1ns/100ps
module axis_command_request_arbiter
   import axis_request_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [DATA_W-1:0] rdData,
   input wire logic haltMode,
   input wire logic [AXES-1:0] opComplete,
   input wire logic [AXES-1:0] errorEvent,
   output logic [AXES-1:0] opStart,
   output logic [AXES-1:0][KIND_W-1:0] opKind,
   output logic [AXES-1:0] busy,
   output logic [AXES-1:0] motionDone,
   output logic [AXES-1:0] axisError,
   output logic [AXES-1:0] forcedStop,
   output logic [AXES-1:0] decelStop,
   output logic [AXES-1:0] pulserEnable,
   output logic [AXES-1:0] jogPosActive,
   output logic [AXES-1:0] jogPosTrigger,
   output logic [AXES-1:0] errorClear,
   output logic [AXES-1:0] servoOn
);

   state_t state_q;
   state_t state_d;
   logic [AXES-1:0][DATA_W-1:0] rise;
   logic [AXES-1:0] stopAny;
   logic [AXES-1:0] running;

   always_comb
   begin
      for (int a = 0; a < AXES; a++)
      begin
         rise[a] = state_q.req[a] & ~state_q.prev[a]; // R26
         stopAny[a] = state_q.req[a][BIT_FORCED] | state_q.req[a][BIT_DECEL];
         running[a] = (state_q.st[a] == AX_RUN);
      end
   end

   always_comb
   begin
      logic hitReq;
      logic hitStat;
      logic [1:0] idx;
      logic [DATA_W-1:0] statWord;
      hitReq = 1'b0;
      hitStat = 1'b0;
      idx = 2'h0;
      statWord = WORD_RESET;
      state_d = state_q;
      state_d.start = '0;
      state_d.trig = '0;
      state_d.error_clear = '0;

      idx = addr[1:0];
      hitReq = ((addr & ~AXIS_IDX_MASK) == ADDR_REQ_BASE); // R22
      hitStat = ((addr & ~AXIS_IDX_MASK) == ADDR_STAT_BASE);

      for (int a = 0; a < AXES; a++)
      begin
         state_d.prev[a] = state_q.req[a];
      end
      if (wrStrobe && hitReq)
      begin
         state_d.req[idx] = wrData; // R22
      end

      for (int a = 0; a < AXES; a++)
      begin
         unique case (state_q.st[a])
            AX_IDLE:
            begin
               // Stop bits and halt mode block every start
               if (!stopAny[a] && !haltMode) // R15
               begin
                  // Fixed priority: lowest request bit wins
                  if (rise[a][BIT_SINGLE]) // R1 R17
                  begin
                     state_d.kind[a] = KIND_SINGLE;
                     state_d.start[a] = 1'b1;
                  end
                  else if (rise[a][BIT_MULTI]) // R2 R17
                  begin
                     state_d.kind[a] = KIND_MULTI;
                     state_d.start[a] = 1'b1;
                  end
                  else if (rise[a][BIT_HOME]) // R3 R17
                  begin
                     state_d.kind[a] = KIND_HOME;
                     state_d.start[a] = 1'b1;
                  end
                  else if (rise[a][BIT_JOG_FWD]) // R4 R17
                  begin
                     state_d.kind[a] = KIND_JOG_FWD;
                     state_d.start[a] = 1'b1;
                  end
                  else if (rise[a][BIT_JOG_REV]) // R4 R17
                  begin
                     state_d.kind[a] = KIND_JOG_REV;
                     state_d.start[a] = 1'b1;
                  end
                  else if (rise[a][BIT_JOGPOS_ARM]) // R8 R17
                  begin
                     state_d.kind[a] = KIND_JOGPOS;
                     state_d.start[a] = 1'b1;
                  end
               end
               if (state_d.start[a])
               begin
                  state_d.st[a] = AX_RUN; // R23
                  state_d.done[a] = 1'b0; // R24
               end
            end
            AX_RUN:
            begin
               // New start requests are not looked at while running
               if (state_q.req[a][BIT_FORCED]) // R5 R25
               begin
                  state_d.st[a] = AX_IDLE;
                  state_d.done[a] = 1'b1; // R24
               end
               else if (opComplete[a]) // R6 R23
               begin
                  state_d.st[a] = AX_IDLE;
                  state_d.done[a] = 1'b1; // R24
               end
               if (state_q.kind[a] == KIND_JOGPOS && state_q.req[a][BIT_JOGPOS_ARM] &&
                   rise[a][BIT_JOGPOS_TRIG] && !stopAny[a]) // R9
               begin
                  state_d.trig[a] = 1'b1;
               end
            end
         endcase

         // Error flag: a new error wins over a clear in the same cycle
         if (rise[a][BIT_ERR_CLEAR] && !stopAny[a]) // R14 R16
         begin
            state_d.err[a] = 1'b0;
            state_d.error_clear[a] = 1'b1;
         end
         if (errorEvent[a])
         begin
            state_d.err[a] = 1'b1;
         end

         // Servo latch, independent of arbitration and of halt mode
         if (rise[a][BIT_SERVO_LOCK]) // R10 R19 R12
         begin
            state_d.servo[a] = 1'b1;
         end
         if (rise[a][BIT_SERVO_REL]) // R11 R19
         begin
            state_d.servo[a] = 1'b0;
         end
      end

      if (rdStrobe)
      begin
         state_d.rdata = WORD_RESET;
         if (hitReq)
         begin
            state_d.rdata = state_q.req[idx];
         end
         else if (hitStat)
         begin
            statWord[STAT_BUSY] = (state_q.st[idx] == AX_RUN);
            statWord[STAT_DONE] = state_q.done[idx];
            statWord[STAT_ERR] = state_q.err[idx];
            statWord[STAT_KIND_LSB +: KIND_W] = state_q.kind[idx];
            state_d.rdata = statWord;
         end
         else if (addr == ADDR_SERVO)
         begin
            state_d.rdata[AXES-1:0] = state_q.servo; // R13
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q.req <= '0;
         state_q.prev <= '0;
         state_q.st <= {AXES{AX_IDLE}};
         state_q.kind <= {AXES{KIND_NONE}};
         state_q.start <= '0;
         state_q.done <= '0;
         state_q.err <= '0;
         state_q.servo <= '0;
         state_q.trig <= '0;
         state_q.error_clear <= '0;
         state_q.rdata <= WORD_RESET;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   always_comb
   begin
      rdData = state_q.rdata;
      opStart = state_q.start;
      motionDone = state_q.done;
      axisError = state_q.err;
      servoOn = state_q.servo;
      jogPosTrigger = state_q.trig;
      errorClear = state_q.error_clear;
      busy = running;
      for (int a = 0; a < AXES; a++)
      begin
         opKind[a] = state_q.kind[a];
         forcedStop[a] = state_q.req[a][BIT_FORCED]; // R5 R25
         decelStop[a] = state_q.req[a][BIT_DECEL] & ~state_q.req[a][BIT_FORCED]; // R6 R25
         pulserEnable[a] = state_q.req[a][BIT_PULSER] & ~stopAny[a]; // R7
         jogPosActive[a] = running[a] && state_q.kind[a] == KIND_JOGPOS &&
                           state_q.req[a][BIT_JOGPOS_ARM]; // R8
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   for (genvar g = 0; g < AXES; g++)
   begin : gen_chk
      chk_stop_blocks_start: assert property (stopAny[g] |=> !opStart[g]) // R15
         else $error("start accepted while a stop bit was high");
      chk_start_on_edge: assert property (opStart[g] |-> $past(rise[g] != '0)) // R26
         else $error("start without a request edge");
      chk_run_ignores_req: assert property ( // R18
         busy[g] && !forcedStop[g] && !opComplete[g] |=> busy[g] && !opStart[g] && $stable(opKind[g]))
         else $error("running operation disturbed by a request");
      chk_forced_ends_now: assert property (busy[g] && forcedStop[g] |=> !busy[g] && motionDone[g]) // R5
         else $error("forced stop did not end the operation at once");
      chk_done_cleared_start: assert property (opStart[g] |-> busy[g] && !motionDone[g]) // R24
         else $error("done or busy wrong at start");
      chk_complete_sets_done: assert property (busy[g] && opComplete[g] |=> !busy[g] && motionDone[g]) // R23
         else $error("completion did not end busy and set done");
      chk_priority_multi: assert property (opStart[g] && opKind[g] == KIND_MULTI |-> $past(!rise[g][BIT_SINGLE])) // R17
         else $error("lower priority request started over a higher one");
      chk_servo_lock_set: assert property ( // R10
         rise[g][BIT_SERVO_LOCK] && !rise[g][BIT_SERVO_REL] |=> servoOn[g])
         else $error("servo lock edge did not set servo on");
      chk_servo_release: assert property (rise[g][BIT_SERVO_REL] |=> !servoOn[g]) // R11
         else $error("servo release edge did not clear servo on");
      chk_servo_holds: assert property ( // R12
         servoOn[g] && !rise[g][BIT_SERVO_REL] |=> servoOn[g])
         else $error("servo on dropped without a release edge");
      chk_error_clear_blocked: assert property (stopAny[g] |=> !errorClear[g]) // R16
         else $error("error clear executed while a stop bit was high");
      chk_stop_exclusive: assert property (!(forcedStop[g] && decelStop[g])) // R25
         else $error("forced and decel stop driven together");
      chk_trig_needs_arm: assert property (jogPosTrigger[g] |-> $past(jogPosActive[g])) // R9
         else $error("trigger without an armed JOG positioning");
      chk_halt_blocks_start: assert property ( // R12
         haltMode
         |=> !opStart[g])
         else $error("start accepted in halt mode");
      chk_start_one_cycle: assert property ( // R26
         opStart[g]
         |=> !opStart[g])
         else $error("start pulse longer than one cycle");
      chk_start_kind_onehot: assert property ( // R17
         opStart[g]
         |-> $onehot(opKind[g]))
         else $error("started kind is not a single request");
      chk_kind_held_idle: assert property ( // R17
         $changed(opKind[g])
         |-> opStart[g])
         else $error("operation kind changed without a start");
      chk_busy_needs_start: assert property ( // R23
         $rose(busy[g])
         |-> opStart[g])
         else $error("busy rose without a start");
      chk_busy_clears_done: assert property ( // R24
         busy[g]
         |-> !motionDone[g])
         else $error("done high while the axis is busy");
      chk_done_falls_start: assert property ( // R24
         $fell(motionDone[g])
         |-> opStart[g])
         else $error("done fell without a new start");
      chk_decel_waits_gen: assert property ( // R6
         busy[g] && decelStop[g] && !opComplete[g]
         |=> busy[g])
         else $error("decel stop ended the operation before completion");
      chk_forced_idle_stays: assert property ( // R5
         !busy[g] && forcedStop[g]
         |=> !busy[g])
         else $error("operation started under a forced stop");
      chk_pulser_stop_gated: assert property ( // R7
         pulserEnable[g]
         |-> !forcedStop[g] && !decelStop[g])
         else $error("pulser enabled during a stop");
      chk_jogpos_needs_run: assert property ( // R8
         jogPosActive[g]
         |-> busy[g] && opKind[g] == KIND_JOGPOS)
         else $error("JOG positioning active outside its operation");
      chk_trig_one_cycle: assert property ( // R9
         jogPosTrigger[g]
         |=> !jogPosTrigger[g])
         else $error("trigger pulse longer than one cycle");
      chk_trig_while_busy: assert property ( // R9
         jogPosTrigger[g]
         |-> $past(busy[g]))
         else $error("trigger while the axis was idle");
      chk_error_sets_flag: assert property ( // R14
         errorEvent[g]
         |=> axisError[g])
         else $error("error event did not set the error flag");
      chk_clear_drops_error: assert property ( // R14
         errorClear[g] && !$past(errorEvent[g])
         |-> !axisError[g])
         else $error("error clear left the error flag set");
      chk_clear_one_cycle: assert property ( // R14
         errorClear[g]
         |=> !errorClear[g])
         else $error("error clear pulse longer than one cycle");
      chk_servo_rise_lock: assert property ( // R10
         $rose(servoOn[g])
         |-> $past(rise[g][BIT_SERVO_LOCK]))
         else $error("servo on rose without a lock edge");
      chk_servo_fall_release: assert property ( // R11
         $fell(servoOn[g])
         |-> $past(rise[g][BIT_SERVO_REL]))
         else $error("servo on fell without a release edge");
   end

   cov_single_start: cover property (opStart[0] && opKind[0] == KIND_SINGLE);
   cov_forced_in_run: cover property (busy[0] && forcedStop[0] ##1 !busy[0]);
   cov_servo_cycle: cover property (servoOn[0] ##[1:20] !servoOn[0]);
   cov_error_cleared: cover property (axisError[0] ##1 errorClear[0]);
   cov_jogpos_trigger: cover property (jogPosTrigger[0]);

endmodule

// [rtl/axis_request_pkg.sv]
// Constants, field positions and types for the four-axis command request block.
// Assumes one 40 MHz clock shared by the host port and the pulse generators.
package axis_request_pkg;
   localparam int AXES = 4;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int KIND_W = 6;

   // Clock figures
   localparam int CLK_PERIOD_NS = 25;

   // Register map
   localparam logic [ADDR_W-1:0] ADDR_REQ_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STAT_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_SERVO = 8'h30;
   localparam logic [ADDR_W-1:0] AXIS_IDX_MASK = 8'h03;
   localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;

   // Request word bit positions
   localparam int BIT_SINGLE = 0;
   localparam int BIT_MULTI = 1;
   localparam int BIT_HOME = 2;
   localparam int BIT_JOG_FWD = 3;
   localparam int BIT_JOG_REV = 4;
   localparam int BIT_FORCED = 5;
   localparam int BIT_DECEL = 6;
   localparam int BIT_PULSER = 7;
   localparam int BIT_JOGPOS_ARM = 8;
   localparam int BIT_JOGPOS_TRIG = 9;
   localparam int BIT_SERVO_LOCK = 10;
   localparam int BIT_SERVO_REL = 11;
   localparam int BIT_ERR_CLEAR = 15;

   // Status word bit positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_ERR = 2;
   localparam int STAT_KIND_LSB = 8;

   typedef enum logic [1:0]
   {
      AX_IDLE = 2'h1,
      AX_RUN = 2'h2
   } axState_t;

   typedef enum logic [KIND_W-1:0]
   {
      KIND_NONE = 6'h00,
      KIND_SINGLE = 6'h01,
      KIND_MULTI = 6'h02,
      KIND_HOME = 6'h04,
      KIND_JOG_FWD = 6'h08,
      KIND_JOG_REV = 6'h10,
      KIND_JOGPOS = 6'h20
   } opKind_t;

   typedef struct packed {
      logic [AXES-1:0][DATA_W-1:0] req;
      logic [AXES-1:0][DATA_W-1:0] prev;
      axState_t [AXES-1:0] st;
      opKind_t [AXES-1:0] kind;
      logic [AXES-1:0] start;
      logic [AXES-1:0] done;
      logic [AXES-1:0] err;
      logic [AXES-1:0] servo;
      logic [AXES-1:0] trig;
      logic [AXES-1:0] error_clear;
      logic [DATA_W-1:0] rdata;
   } state_t;
endpackage

// [verification/pulse_gen_model.sv]
// Behavioural pulse generators of four axes, the far side of the request block.
// Assumes opStart and the stop levels come from the block on clk.
`timescale 1ns/100ps
module pulse_gen_model
   import axis_request_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [AXES-1:0] opStart,
   input wire logic [AXES-1:0] forcedStop,
   input wire logic [AXES-1:0] decelStop,
   input wire logic [7:0] lat,
   input wire logic [AXES-1:0] errReq,
   output logic [AXES-1:0] opComplete,
   output logic [AXES-1:0] errorEvent
);
   logic [AXES-1:0][7:0] cnt;
   always_ff @(posedge clk)
   begin
      errorEvent <= rst_n ? errReq : '0;
      for (int i = 0; i < AXES; i++)
      begin
         opComplete[i] <= rst_n && cnt[i] == 8'h01 && !forcedStop[i];
         if (!rst_n || forcedStop[i] || cnt[i] == 8'h01)
            cnt[i] <= 8'h00;
         else if (opStart[i])
            cnt[i] <= lat;
         else if (decelStop[i] && cnt[i] > 8'h03)
            cnt[i] <= 8'h03;
         else if (cnt[i] != 8'h00)
            cnt[i] <= cnt[i] - 8'h01;
      end
   end
endmodule

// [verification/axis_command_request_arbiter_tb.sv]
// Self-checking bench of the four-axis request block.
// Assumes pulse_gen_model as generators; read results checked through a queue.
`timescale 1ns/100ps
module axis_command_request_arbiter_tb
   import axis_request_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wrData = '0;
   logic wrStrobe = 1'b0;
   logic rdStrobe = 1'b0;
   logic haltMode = 1'b0;
   logic [7:0] lat = 8'h04;
   logic [AXES-1:0] errReq = '0;
   logic [DATA_W-1:0] rdData;
   logic [AXES-1:0] opComplete, errorEvent, opStart, busy, motionDone, axisError;
   logic [AXES-1:0] forcedStop, decelStop, pulserEnable, jogPosActive, jogPosTrigger, errorClear, servoOn;
   logic [AXES-1:0][KIND_W-1:0] opKind;
   logic rdPend = 1'b0;
   logic [DATA_W-1:0] expQ[$];
   logic [DATA_W-1:0] bits [6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0100};
   logic [KIND_W-1:0] kinds [6] = '{KIND_SINGLE, KIND_MULTI, KIND_HOME, KIND_JOG_FWD, KIND_JOG_REV, KIND_JOGPOS};
   int n_fail = 0;
   int check_count = 0;
   int trigCount = 0;
   int cyc = 0;
   int ax;

   always #(CLK_PERIOD_NS / 2.0) clk = ~clk;

   axis_command_request_arbiter u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .haltMode(haltMode),
      .opComplete(opComplete), .errorEvent(errorEvent), .opStart(opStart), .opKind(opKind),
      .busy(busy), .motionDone(motionDone), .axisError(axisError), .forcedStop(forcedStop),
      .decelStop(decelStop), .pulserEnable(pulserEnable), .jogPosActive(jogPosActive),
      .jogPosTrigger(jogPosTrigger), .errorClear(errorClear), .servoOn(servoOn));

   pulse_gen_model u_gen (.clk(clk), .rst_n(rst_n), .opStart(opStart), .forcedStop(forcedStop),
      .decelStop(decelStop), .lat(lat), .errReq(errReq), .opComplete(opComplete), .errorEvent(errorEvent));

   task automatic close_out();
      if (n_fail == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   // Result monitor: read data stand in the cycle after the strobe
   always @(posedge clk)
   begin
      if (rdPend)
         chk(expQ.pop_front(), rdData);
      rdPend <= rdStrobe;
      trigCount <= trigCount + $countones(jogPosTrigger);
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         close_out();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'b1;
      expQ.push_back(e);
      @(posedge clk);
      rdStrobe <= 1'b0;
   endtask

   task automatic req(input logic [DATA_W-1:0] d);
      wr(ADDR_REQ_BASE + 8'(ax), d);
   endtask

   task automatic stat(input logic b, input logic d, input logic e, input logic [KIND_W-1:0] k);
      rd(ADDR_STAT_BASE + 8'(ax), {2'h0, k, 5'h00, e, d, b});
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy[ax] !== 1'b0 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      chk(16'h0000, 16'(n >= 200));
      tick(2);
   endtask

   initial
   begin
      ax = $urandom(80);
      tick(4);
      rst_n <= 1'b1;
      for (ax = 0; ax < AXES; ax++)
         stat(1'b0, 1'b0, 1'b0, KIND_NONE);
      wr(8'h20, 16'hffff);
      rd(8'h20, 16'h0000);
      rd(ADDR_SERVO, 16'h0000);
      ax = $urandom_range(3);
      req(16'h0420);
      req(16'h0000);
      haltMode <= 1'b1;
      tick(3);
      rd(ADDR_SERVO, 16'(1 << ax));
      chk(16'h0001, 16'(servoOn[ax]));
      req(16'h0801);
      tick(1);
      haltMode <= 1'b0;
      tick(2);
      rd(ADDR_SERVO, 16'h0000);
      stat(1'b0, 1'b0, 1'b0, KIND_NONE);
      req(16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         ax = $urandom_range(3);
         lat <= 8'($urandom_range(1, 8));
         req(bits[i]);
         tick(1);
         #1;
         chk(16'h0001, 16'(opStart[ax]));
         chk(16'(kinds[i]), 16'(opKind[ax]));
         wait_idle();
         stat(1'b0, 1'b1, 1'b0, kinds[i]);
         req(16'h0000);
      end
      ax = $urandom_range(3);
      lat <= 8'h28;
      req(16'h001e);
      tick(2);
      stat(1'b1, 1'b0, 1'b0, KIND_MULTI);
      req(16'h011f);
      tick(2);
      stat(1'b1, 1'b0, 1'b0, KIND_MULTI);
      req(16'h007f);
      tick(1);
      #1;
      chk(16'h0002, 16'({forcedStop[ax], decelStop[ax]}));
      stat(1'b0, 1'b1, 1'b0, KIND_MULTI);
      req(16'h0060);
      rd(ADDR_REQ_BASE + 8'(ax), 16'h0060);
      req(16'h0061);
      errReq[ax] <= 1'b1;
      tick(1);
      errReq <= '0;
      req(16'h8060);
      tick(2);
      stat(1'b0, 1'b1, 1'b1, KIND_MULTI);
      req(16'h0000);
      req(16'h8000);
      tick(1);
      #1;
      chk(16'h0001, 16'(errorClear[ax]));
      tick(1);
      stat(1'b0, 1'b1, 1'b0, KIND_MULTI);
      req(16'h8001);
      tick(3);
      req(16'h0041);
      wait_idle();
      stat(1'b0, 1'b1, 1'b0, KIND_SINGLE);
      req(16'h0080);
      tick(1);
      #1;
      chk(16'h0001, 16'(pulserEnable[ax]));
      req(16'h00c0);
      tick(1);
      #1;
      chk(16'h0000, 16'(pulserEnable[ax]));
      req(16'h0200);
      req(16'h0000);
      req(16'h0100);
      tick(2);
      #1;
      chk(16'h0001, 16'(jogPosActive[ax]));
      req(16'h0300);
      tick(2);
      #1;
      chk(16'h0001, 16'(trigCount));
      req(16'h0000);
      wait_idle();
      close_out();
   end
endmodule
